// file: charger_powerpath_int_regs.sv
// Charger and power-path register bank with its I2C slave and interrupt pin
//
// Summary of operation
// R1 - Bit 7 shows USB source present, valid
// R2 - Bit 6 shows adapter source present, valid
// R3 - Bits 5/4 suspend USB/adapter inputs, reset 0
// R4 - Adapter current field bits 3..2, default 11
// R5 - USB current field bits 1..0, default 01
// R6 - Clear safety timers when both inputs absent
// R7 - Input-change mask drives interrupt on input flags
// R8 - Touch and button masks gate their interrupts
// R9 - Touch flag set on touch, read clears
// R10 - Button flag set on press, read clears
// R11 - Input-applied flag sticky until read
// R12 - Input-removed flag sticky until read
// R13 - Status bit 7 shows thermal regulation
// R14 - Status bit 6 shows power-path loop active
// R15 - Status bit 5 shows thermal suspend
// R16 - Status bit 4 shows termination reached
// R17 - Status bits 2/1 show timer expirations
// R18 - Status bit 0 shows missing temperature sensor
// R19 - Timer config bits 7..6 select timeout hours
// R20 - Timer config bit 5 enables charge timers
// R21 - Current fields reload on removal or lockout
// R22 - I2C slave address 1001000, unlisted read 00h
// R23 - Unused interrupt/status bits read zero
`timescale 1ns/1ps
module charger_powerpath_int_regs (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic usb_present,
    input wire logic ac_present,
    input wire logic under_voltage_lockout,
    input wire logic touch_detect,
    input wire logic push_button_input,
    input wire logic push_button_active_high,
    input wire logic thermal_regulation,
    input wire logic dynamic_power_path_loop,
    input wire logic thermal_suspend,
    input wire logic term_current_reached,
    input wire logic fast_charge_timeout,
    input wire logic precharge_timeout,
    input wire logic bat_temp_error,
    output logic usb_suspend,
    output logic ac_suspend,
    output logic [1:0] ac_current_limit,
    output logic [1:0] usb_current_limit,
    output logic [1:0] safety_timer_value,
    output logic safety_timer_enable,
    output logic [4:0] timer_config_low,
    output logic safety_timer_clear,
    output logic int_n_out,
    output logic int_n_oe
);
    i2c_reg_if bus ();

    logic usb_q, ac_q, touch_q, button_q;
    logic [2:0] mask_q;
    logic [3:0] flags_q;
    logic [7:0] timer_cfg_q;
    logic [7:0] rdata_c;
    logic button_level;
    logic any_input;
    logic rd_int;
    logic [3:0] seen_q;
    logic [3:0] set_c;
    logic [3:0] clr_c;

    // ==========================================================
    // I2C slave
    i2c_reg_slave slave_u (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .bus(bus.slave)
    );

    assign button_level = push_button_active_high ? push_button_input : ~push_button_input; // R10
    assign any_input = usb_present | ac_present;
    assign rd_int = bus.rd_stb && bus.addr == charger_regs_pkg::INTERRUPT_MASK_FLAGS_ADDR;
    // Strobe lags the data capture, so clear only the bits that were shifted out
    assign clr_c = rd_int ? seen_q : 4'h0;

    // ==========================================================
    // Input history for edge detection
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            usb_q <= 1'b0;
            ac_q <= 1'b0;
            touch_q <= 1'b0;
            button_q <= 1'b0;
        end else if (clk_en) begin
            usb_q <= usb_present;
            ac_q <= ac_present;
            touch_q <= touch_detect;
            button_q <= button_level;
        end
    end

    // ==========================================================
    // Power-path control register
    always_ff @(posedge ref_clk) begin
        if (!rst_n || under_voltage_lockout) begin
            usb_suspend <= 1'b0; // R3
            ac_suspend <= 1'b0;
            ac_current_limit <= charger_regs_pkg::AC_CURRENT_RESET; // R4
            usb_current_limit <= charger_regs_pkg::USB_CURRENT_RESET; // R5
        end else if (clk_en) begin
            if (bus.wr_stb && bus.addr == charger_regs_pkg::POWER_PATH_CONTROL_ADDR) begin
                usb_suspend <= bus.wdata[charger_regs_pkg::PP_USB_SUSPEND_BIT]; // R3
                ac_suspend <= bus.wdata[charger_regs_pkg::PP_AC_SUSPEND_BIT];
                ac_current_limit <= bus.wdata[3:2]; // R4
                usb_current_limit <= bus.wdata[1:0]; // R5
            end
            if (ac_q && !ac_present) begin
                ac_current_limit <= charger_regs_pkg::AC_CURRENT_RESET; // R21
            end
            if (usb_q && !usb_present) begin
                usb_current_limit <= charger_regs_pkg::USB_CURRENT_RESET; // R21
            end
        end
    end

    // ==========================================================
    // Interrupt masks and sticky flags
    always_comb begin
        set_c = 4'h0;
        set_c[charger_regs_pkg::INT_TOUCH_BIT] = touch_detect & ~touch_q; // R9
        set_c[charger_regs_pkg::INT_BUTTON_BIT] = button_level & ~button_q; // R10
        set_c[charger_regs_pkg::INT_APPLIED_BIT] =
            (usb_present & ~usb_q) | (ac_present & ~ac_q); // R11
        set_c[charger_regs_pkg::INT_REMOVED_BIT] =
            (usb_q & ~usb_present) | (ac_q & ~ac_present); // R12
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || under_voltage_lockout) begin
            mask_q <= charger_regs_pkg::INT_MASK_RESET;
            flags_q <= charger_regs_pkg::INT_FLAGS_RESET;
            seen_q <= charger_regs_pkg::INT_FLAGS_RESET;
        end else if (clk_en) begin
            if (bus.wr_stb && bus.addr == charger_regs_pkg::INTERRUPT_MASK_FLAGS_ADDR) begin
                mask_q <= bus.wdata[7:5];
            end
            // Read clears what was read, a new event wins
            flags_q <= set_c | (flags_q & ~clr_c); // R9 R10 R11 R12
            seen_q <= flags_q;
        end
    end

    // ==========================================================
    // Timer configuration register
    always_ff @(posedge ref_clk) begin
        if (!rst_n || under_voltage_lockout) begin
            timer_cfg_q <= charger_regs_pkg::CHARGER_TIMER_CONFIG_RESET;
        end else if (clk_en) begin
            if (bus.wr_stb && bus.addr == charger_regs_pkg::CHARGER_TIMER_CONFIG_ADDR) begin
                timer_cfg_q <= bus.wdata; // R19 R20
            end
        end
    end

    assign safety_timer_value = timer_cfg_q[7:6]; // R19
    assign safety_timer_enable = timer_cfg_q[charger_regs_pkg::TC_TIMER_ENABLE_BIT]; // R20
    assign timer_config_low = timer_cfg_q[4:0];

    // ==========================================================
    // Safety timer clear and interrupt pin
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            safety_timer_clear <= 1'b0;
            int_n_oe <= 1'b0;
        end else if (clk_en) begin
            safety_timer_clear <= ~any_input; // R6
            int_n_oe <= (mask_q[2] & (flags_q[1] | flags_q[0])) | // R7
                (mask_q[1] & flags_q[3]) | (mask_q[0] & flags_q[2]); // R8
        end
    end

    assign int_n_out = 1'b0;

    // ==========================================================
    // Read mux
    always_comb begin
        rdata_c = charger_regs_pkg::UNMAPPED_VALUE; // R22
        unique case (bus.addr)
            charger_regs_pkg::POWER_PATH_CONTROL_ADDR: begin
                rdata_c = {usb_present, ac_present, usb_suspend, ac_suspend, // R1 R2
                    ac_current_limit, usb_current_limit};
            end
            charger_regs_pkg::INTERRUPT_MASK_FLAGS_ADDR: begin
                rdata_c = {mask_q, 1'b0, flags_q}; // R23
            end
            charger_regs_pkg::CHARGER_STATUS_ADDR: begin
                rdata_c = {thermal_regulation, dynamic_power_path_loop, thermal_suspend, // R13 R14 R15
                    term_current_reached, 1'b0, fast_charge_timeout, // R16 R23
                    precharge_timeout, bat_temp_error}; // R17 R18
            end
            charger_regs_pkg::CHARGER_TIMER_CONFIG_ADDR: begin
                rdata_c = timer_cfg_q;
            end
            default: begin
                rdata_c = charger_regs_pkg::UNMAPPED_VALUE;
            end
        endcase
    end

    assign bus.rdata = rdata_c;
endmodule

// file: charger_regs_pkg.sv
// Package holding offsets, field positions, reset values and I2C constants for the register bank
package charger_regs_pkg;

    // ==========================================================
    // I2C slave
    localparam logic [6:0] SLAVE_ADDR = 7'h48;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] POWER_PATH_CONTROL_ADDR = 8'h01;
    localparam logic [7:0] INTERRUPT_MASK_FLAGS_ADDR = 8'h02;
    localparam logic [7:0] CHARGER_STATUS_ADDR = 8'h03;
    localparam logic [7:0] CHARGER_TIMER_CONFIG_ADDR = 8'h04;

    // ==========================================================
    // Field positions
    localparam int PP_USB_PRESENT_BIT = 7;
    localparam int PP_AC_PRESENT_BIT = 6;
    localparam int PP_USB_SUSPEND_BIT = 5;
    localparam int PP_AC_SUSPEND_BIT = 4;
    localparam int INT_MASK_INPUT_BIT = 7;
    localparam int INT_MASK_TOUCH_BIT = 6;
    localparam int INT_MASK_BUTTON_BIT = 5;
    localparam int INT_TOUCH_BIT = 3;
    localparam int INT_BUTTON_BIT = 2;
    localparam int INT_APPLIED_BIT = 1;
    localparam int INT_REMOVED_BIT = 0;
    localparam int TC_TIMER_ENABLE_BIT = 5;

    // ==========================================================
    // Values after reset or lockout
    localparam logic [1:0] AC_CURRENT_RESET = 2'h3;
    localparam logic [1:0] USB_CURRENT_RESET = 2'h1;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;
    localparam logic [3:0] INT_FLAGS_RESET = 4'h0;
    localparam logic [7:0] CHARGER_TIMER_CONFIG_RESET = 8'h31;

endpackage

// file: charger_regs_properties.sv
// Checker for the charger register bank ports
`timescale 1ns/1ps
module charger_regs_properties (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic usb_present,
    input wire logic ac_present,
    input wire logic under_voltage_lockout,
    input wire logic usb_suspend,
    input wire logic ac_suspend,
    input wire logic [1:0] ac_current_limit,
    input wire logic [1:0] usb_current_limit,
    input wire logic [1:0] safety_timer_value,
    input wire logic safety_timer_enable,
    input wire logic [4:0] timer_config_low,
    input wire logic safety_timer_clear,
    input wire logic int_n_out,
    input wire logic int_n_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Reload sequences
    sequence s_usb_dflt;
        ##[1:2] usb_current_limit == charger_regs_pkg::USB_CURRENT_RESET;
    endsequence
    sequence s_ac_dflt;
        ##[1:2] ac_current_limit == charger_regs_pkg::AC_CURRENT_RESET;
    endsequence
    // ==========
    // Properties
    a_clear_both_absent: assert property (
        clk_en && !usb_present && !ac_present |=> safety_timer_clear)
        else $error("timer clear missing");
    a_clear_one_present: assert property (
        clk_en && (usb_present || ac_present) |=> !safety_timer_clear)
        else $error("timer clear while powered");
    a_lockout_reload: assert property (
        clk_en && under_voltage_lockout |=>
        {usb_suspend, ac_suspend, ac_current_limit, usb_current_limit} == 6'h0D &&
        {safety_timer_value, safety_timer_enable, timer_config_low} == 8'h31)
        else $error("lockout did not reload");
    a_usb_removal_reload: assert property ($fell(usb_present) |-> s_usb_dflt)
        else $error("usb limit not reloaded");
    a_ac_removal_reload: assert property ($fell(ac_present) |-> s_ac_dflt)
        else $error("adapter limit not reloaded");
    a_int_drive_low: assert property (int_n_out == 1'b0)
        else $error("interrupt pin driven high");
    a_int_lockout_quiet: assert property (
        clk_en && under_voltage_lockout ##1 clk_en |=> !int_n_oe)
        else $error("interrupt held through lockout");
    a_sda_drive_low: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved with clock high");
    a_cfg_scl_low: assert property (
        $changed({usb_suspend, ac_suspend, safety_timer_value, safety_timer_enable,
        timer_config_low}) |-> !scl_in || $past(under_voltage_lockout))
        else $error("config changed outside a write");
endmodule

bind charger_powerpath_int_regs charger_regs_properties i_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .usb_present(usb_present), .ac_present(ac_present),
    .under_voltage_lockout(under_voltage_lockout), .usb_suspend(usb_suspend),
    .ac_suspend(ac_suspend), .ac_current_limit(ac_current_limit),
    .usb_current_limit(usb_current_limit), .safety_timer_value(safety_timer_value),
    .safety_timer_enable(safety_timer_enable), .timer_config_low(timer_config_low),
    .safety_timer_clear(safety_timer_clear), .int_n_out(int_n_out), .int_n_oe(int_n_oe)
);

// file: i2c_host_model.sv
// Behavioural I2C host reaching the register bank
`timescale 1ns/1ps
module i2c_host_model #(
    parameter int QTR = 6
) (
    input wire logic ref_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_drv,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    logic line;
    // Pull-up on the data line
    assign line = sda_drv & ~sda_oe;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        rd_data = 8'h00;
        rd_valid = 1'b0;
    end
    // ==========
    // Bus steps
    task automatic step(input logic c, input logic d);
        scl = c;
        sda_drv = d;
        repeat (QTR) @(negedge ref_clk);
    endtask
    task automatic start_cond();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        r = line;
        step(1'b1, b);
        step(1'b0, b);
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(1'b1, a);
    endtask
    // ==========
    // Transfers
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d);
        logic [7:0] r;
        start_cond();
        byte_io({dev, 1'b0}, r);
        byte_io(ra, r);
        byte_io(d, r);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra);
        logic [7:0] r;
        start_cond();
        byte_io({dev, 1'b0}, r);
        byte_io(ra, r);
        start_cond();
        byte_io({dev, 1'b1}, r);
        byte_io(8'hFF, r);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        rd_data = r;
        rd_valid = 1'b1;
        @(negedge ref_clk);
        rd_valid = 1'b0;
    endtask
endmodule

// file: i2c_reg_if.sv
// Interface carrying register accesses from the I2C slave to the register bank
`timescale 1ns/1ps
interface i2c_reg_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rdata;

    modport slave (output addr, output wdata, output wr_stb, output rd_stb, input rdata);
    modport bank (input addr, input wdata, input wr_stb, input rd_stb, output rdata);
endinterface

// file: i2c_reg_slave.sv
// I2C slave that turns bus transfers into register read and write strobes
`timescale 1ns/1ps
module i2c_reg_slave (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    i2c_reg_if.slave bus
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_WRITE = 3'b011,
        ST_READ = 3'b100,
        ST_RACK = 3'b101
    } i2c_state_e;

    i2c_state_e state_q;
    logic scl_q, sda_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic rnw_q, have_ptr_q, acked_q;
    logic [7:0] ptr_q;

    wire scl_rise = scl_in & ~scl_q;
    wire scl_fall = ~scl_in & scl_q;
    wire start_c = scl_in & scl_q & sda_q & ~sda_in;
    wire stop_c = scl_in & scl_q & ~sda_q & sda_in;

    assign sda_out = 1'b0;
    assign bus.addr = ptr_q;

    // ==========================================================
    // Line history
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (clk_en) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // ==========================================================
    // Protocol state machine
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
            rnw_q <= 1'b0;
            have_ptr_q <= 1'b0;
            ptr_q <= 8'h00;
            acked_q <= 1'b0;
            sda_oe <= 1'b0;
            bus.wdata <= 8'h00;
            bus.wr_stb <= 1'b0;
            bus.rd_stb <= 1'b0;
        end else if (clk_en) begin
            bus.wr_stb <= 1'b0;
            bus.rd_stb <= 1'b0;
            if (start_c) begin
                state_q <= ST_ADDR;
                cnt_q <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state_q <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_WRITE: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_in};
                            cnt_q <= cnt_q + 4'h1;
                        end
                        if (scl_fall && cnt_q == 4'h8) begin
                            cnt_q <= 4'h0;
                            if (state_q == ST_ADDR) begin
                                if (shift_q[7:1] == charger_regs_pkg::SLAVE_ADDR) begin // R22
                                    rnw_q <= shift_q[0];
                                    have_ptr_q <= 1'b0;
                                    sda_oe <= 1'b1;
                                    state_q <= ST_ACK;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                if (!have_ptr_q) begin
                                    ptr_q <= shift_q;
                                    have_ptr_q <= 1'b1;
                                end else begin
                                    bus.wdata <= shift_q;
                                    bus.wr_stb <= 1'b1;
                                end
                                sda_oe <= 1'b1;
                                state_q <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (rnw_q) begin
                                bus.rd_stb <= 1'b1;
                                sda_oe <= ~bus.rdata[7];
                                shift_q <= {bus.rdata[6:0], 1'b1};
                                cnt_q <= 4'h1;
                                state_q <= ST_READ;
                            end else begin
                                if (have_ptr_q && bus.wr_stb == 1'b0 && cnt_q == 4'h0 &&
                                    acked_q) begin
                                    ptr_q <= ptr_q + 8'h01;
                                end
                                acked_q <= have_ptr_q;
                                sda_oe <= 1'b0;
                                state_q <= ST_WRITE;
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            if (cnt_q == 4'h8) begin
                                sda_oe <= 1'b0;
                                ptr_q <= ptr_q + 8'h01;
                                state_q <= ST_RACK;
                            end else begin
                                sda_oe <= ~shift_q[7];
                                shift_q <= {shift_q[6:0], 1'b1};
                                cnt_q <= cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            state_q <= sda_in ? ST_IDLE : ST_ACK;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// file: test_charger_powerpath_int_regs.sv
// Self-checking bench for the charger register bank
`timescale 1ns/1ps
module test_charger_powerpath_int_regs;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic usb_present = 1'b0;
    logic ac_present = 1'b0;
    logic under_voltage_lockout = 1'b0;
    logic touch_detect = 1'b0;
    logic push_button_input = 1'b1;
    logic [6:0] stat = 7'h00;
    logic prb = 1'b0;
    logic pb_high = 1'b0;
    logic scl, sda_drv, sda_oe, sda_out, rd_valid, usb_suspend, ac_suspend;
    logic safety_timer_enable, safety_timer_clear, int_n_out, int_n_oe;
    logic [1:0] ac_current_limit, usb_current_limit, safety_timer_value;
    logic [4:0] timer_config_low;
    logic [7:0] rd_data, p1, p2, d, msk;
    logic [5:0] pp;
    logic [9:0] note;
    logic [9:0] notes[$];
    logic [7:0] f1[3] = '{8'h02, 8'h08, 8'h04};
    logic [7:0] f2[3] = '{8'h01, 8'h08, 8'h04};
    int failures = 0;
    int tests_run = 0;
    assign p1 = {int_n_oe, safety_timer_clear, usb_suspend, ac_suspend, ac_current_limit,
        usb_current_limit};
    assign p2 = {safety_timer_value, safety_timer_enable, timer_config_low};
    always #2.5 ref_clk = ~ref_clk;
    i2c_host_model i_host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda_drv(sda_drv),
        .rd_data(rd_data), .rd_valid(rd_valid));
    charger_powerpath_int_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .scl_in(scl), .sda_in(sda_drv & ~sda_oe), .sda_out(sda_out), .sda_oe(sda_oe),
        .usb_present(usb_present), .ac_present(ac_present),
        .under_voltage_lockout(under_voltage_lockout), .touch_detect(touch_detect),
        .push_button_input(push_button_input), .push_button_active_high(pb_high),
        .thermal_regulation(stat[6]), .dynamic_power_path_loop(stat[5]),
        .thermal_suspend(stat[4]), .term_current_reached(stat[3]),
        .fast_charge_timeout(stat[2]), .precharge_timeout(stat[1]), .bat_temp_error(stat[0]),
        .usb_suspend(usb_suspend), .ac_suspend(ac_suspend), .ac_current_limit(ac_current_limit),
        .usb_current_limit(usb_current_limit), .safety_timer_value(safety_timer_value),
        .safety_timer_enable(safety_timer_enable), .timer_config_low(timer_config_low),
        .safety_timer_clear(safety_timer_clear), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
    // ==========
    // Helpers
    task automatic check(input logic [1:0] sel, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", sel == 2'h0 ? "read data" : "port bits",
                exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
        notes.push_back({2'h0, exp});
        i_host.read_reg(charger_regs_pkg::SLAVE_ADDR, ra);
    endtask
    task automatic wr(input logic [7:0] ra, input logic [7:0] v);
        i_host.write_reg(charger_regs_pkg::SLAVE_ADDR, ra, v);
    endtask
    task automatic probe(input logic [1:0] sel, input logic [7:0] exp);
        notes.push_back({sel, exp});
        @(negedge ref_clk);
        prb = 1'b1;
        @(negedge ref_clk);
        prb = 1'b0;
    endtask
    function automatic logic [7:0] ports(input logic irq);
        return {irq, ~(usb_present | ac_present), pp};
    endfunction
    task automatic fire(input int k);
        case (k)
            0: usb_present = ~usb_present;
            1: touch_detect = 1'b1;
            default: push_button_input = 1'b0;
        endcase
        repeat (3) @(negedge ref_clk);
        touch_detect = 1'b0;
        push_button_input = 1'b1;
        repeat (5) @(negedge ref_clk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========
    // Result watcher
    always @(posedge ref_clk) begin
        if (rd_valid || prb) begin
            note = notes.pop_front();
            check(note[9:8], note[9:8] == 2'h0 ? rd_data : (note[9:8] == 2'h1 ? p1 : p2),
                note[7:0]);
        end
    end
    initial begin
        #300000;
        failures++;
        tally_and_finish();
    end
    // ==========
    // Scenarios
    initial begin
        void'($urandom(32'hD7BB));
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        pp = 6'h0D;
        probe(2'h1, ports(1'b0));
        probe(2'h2, charger_regs_pkg::CHARGER_TIMER_CONFIG_RESET);
        rd(8'h04, 8'h31);
        wr(8'h03, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            {usb_present, ac_present} = 2'(i);
            stat = 7'($urandom());
            pp = {2'(i), 2'(i), ~2'(i)};
            wr(8'h01, {2'h3, pp});
            probe(2'h1, ports(1'b0));
            rd(8'h01, {usb_present, ac_present, pp});
            rd(8'h03, {stat[6:3], 1'b0, stat[2:0]});
            d = {2'(i), 6'($urandom())};
            wr(8'h04, d);
            probe(2'h2, d);
            rd(8'h04, d);
        end
        {usb_present, ac_present} = 2'h0;
        pp[3:0] = 4'hD;
        repeat (4) @(negedge ref_clk);
        rd(8'h02, 8'h03);
        rd(8'h01, {2'h0, pp});
        wr(8'h07, 8'h5A);
        rd(8'h07, 8'h00);
        notes.push_back({2'h0, 8'hFF});
        i_host.read_reg(7'h49, 8'h04);
        for (int k = 0; k < 3; k++) begin
            msk = 8'h80 >> k;
            wr(8'h02, msk | 8'h1F);
            fire(k);
            probe(2'h1, ports(1'b1));
            rd(8'h02, msk | f1[k]);
            probe(2'h1, ports(1'b0));
            wr(8'h02, 8'h1F);
            fire(k);
            probe(2'h1, ports(1'b0));
            rd(8'h02, f2[k]);
        end
        wr(8'h02, 8'hE0);
        push_button_input = 1'b0;
        pb_high = 1'b1;
        fire(2);
        probe(2'h1, ports(1'b1));
        under_voltage_lockout = 1'b1;
        @(negedge ref_clk);
        under_voltage_lockout = 1'b0;
        pp = 6'h0D;
        probe(2'h1, ports(1'b0));
        probe(2'h2, 8'h31);
        rd(8'h02, 8'h00);
        repeat (10) @(negedge ref_clk);
        tally_and_finish();
    end
endmodule
